// ==== common/pia_cfg.svh ====
`ifndef PIA_CFG_SVH
`define PIA_CFG_SVH
// How it works
// - taking a level sets its in-service latch
// - only the special status load clears latches
// - lowest-numbered enabled requesting level wins
// - latch blocks its level and all lower
// - higher levels nest, setting their own latch
// - 32-bit enable mask, one bit per level
// - honor: enabled, highest enabled, not blocked
// - unhonored requests stay pending until cancelled
// - system reset clears the enable mask
// - mask update ORs or ANDs fetched word; with only the cancel bit set the mask is unchanged
// - mask update may cancel tagged pending requests
// - no latch set: special load is ordinary
// - special load loads word, releases highest latch
// - misaligned operand or flags: specification, suppressed
// - key and address taken unchecked from doubleword
// - code and length fields not retained
// - condition code from loaded bits 34-35
// - absent feature or problem state suppress; faults terminate
// - sync basic first, then priority after delay
// - priority before external or I/O interruption
// - status loads never touch the enable mask
// - timer access defers interruptions one instruction
// - drive level number, then raise outbound strobe
// - inbound strobe rise samples the description byte
// - word bits 0-31 map to levels 0-31
`define LEVELS 32
`define LEVEL_W 5
`define MASK_RESET 32'h0000_0000
`define MU_OR_BIT 7
`define MU_CANCEL_BIT 6
`define PSW_KEY 55:52
`define PSW_CODE 47:32
`define PSW_ILC 31:30
`define PSW_CC 29:28
`define PSW_IA 23:0
`define CLOCK_MHZ 125
`define BASIC_DELAY_US 4
`define BASIC_DELAY_CYC (`BASIC_DELAY_US * `CLOCK_MHZ)
`define DELAY_W 10
`endif

// ==== common/pia_pkg.sv ====
package pia_pkg;
    typedef enum logic [3:0] {
        ST_IDLE = 4'b0001,
        ST_DELAY = 4'b0010,
        ST_TAKE = 4'b0100,
        ST_STROBE = 4'b1000
    } state_t;
    typedef enum logic [2:0] {
        EXC_NONE = 3'h0,
        EXC_OPERATION = 3'h1,
        EXC_PRIVILEGED = 3'h2,
        EXC_SPECIFICATION = 3'h3,
        EXC_TERMINATED = 3'h4
    } exc_t;
endpackage

// ==== common/level_select_if.sv ====
`timescale 1ns/1ps
interface level_select_if;
    logic clock;
    logic nrst;
    logic [31:0] pending;
    logic [31:0] mask;
    logic [31:0] in_service;
    logic grant_valid;
    logic [4:0] grant_level;
    logic top_valid;
    logic [4:0] top_level;
    modport arbiter (input clock, nrst, pending, mask, in_service,
        output grant_valid, grant_level, top_valid, top_level);
    modport owner (output clock, nrst, pending, mask, in_service,
        input grant_valid, grant_level, top_valid, top_level);
endinterface

// ==== logic/level_select.sv ====
`timescale 1ns/1ps
`include "pia_cfg.svh"
module level_select (
    level_select_if.arbiter sel
);
    logic [31:0] req;
    logic cand_valid;
    logic [4:0] cand_level;
    logic blocked;

    assign req = sel.pending & sel.mask;

    // descending scan so the lowest index is the last to win
    always_comb
    begin
        cand_valid = 1'b0;
        cand_level = 5'h0;
        sel.top_valid = 1'b0;
        sel.top_level = 5'h0;
        for (int i = `LEVELS - 1; i >= 0; i--)
        begin
            if (req[i])
            begin
                cand_valid = 1'b1;
                cand_level = 5'(i);
            end
            if (sel.in_service[i])
            begin
                sel.top_valid = 1'b1;
                sel.top_level = 5'(i);
            end
        end
    end

    assign blocked = sel.top_valid && (sel.top_level <= cand_level);
    assign sel.grant_valid = cand_valid && !blocked;
    assign sel.grant_level = cand_level;

    ////////////////////////////////////////////////////////////////////
    a_grant_lowest: assert property (@(posedge sel.clock) disable iff (!sel.nrst)
        sel.grant_valid |-> (req & ((32'h0000_0001 << sel.grant_level) - 32'h0000_0001)) == 0)
        else $error("grant not the lowest enabled level");
    a_grant_blocked: assert property (@(posedge sel.clock) disable iff (!sel.nrst)
        sel.grant_valid && sel.top_valid |-> sel.grant_level < sel.top_level)
        else $error("grant at or below an in-service level");
endmodule // level_select

// ==== logic/priority_interrupt_arbiter.sv ====
`timescale 1ns/1ps
`include "pia_cfg.svh"
module priority_interrupt_arbiter (
    input wire logic i_clock,
    input wire logic i_nrst,
    input wire logic [31:0] i_request,
    output logic [4:0] o_accepted_level,
    output logic o_timing_out,
    input wire logic i_timing_in,
    input wire logic [7:0] i_description,
    output logic [7:0] o_description,
    output logic o_description_valid,
    input wire logic i_instr_end,
    input wire logic i_wait_state,
    input wire logic i_basic_sync,
    input wire logic i_basic_async,
    output logic o_basic_first,
    output logic o_exchange,
    output logic o_hold_async,
    input wire logic i_timer_fitted,
    input wire logic i_timer_access,
    output logic o_deferred,
    input wire logic i_feature_present,
    input wire logic i_problem_state,
    input wire logic i_mask_update,
    input wire logic [7:0] i_instr_flags,
    input wire logic [2:0] i_operand_low,
    input wire logic [31:0] i_operand_word,
    input wire logic i_operand_fault,
    input wire logic i_status_load,
    input wire logic i_load_special,
    input wire logic [63:0] i_load_dword,
    output logic [63:0] o_status_word,
    output logic [3:0] o_protection_key,
    output logic [23:0] o_instr_address,
    output logic [1:0] o_cond_code,
    output pia_pkg::exc_t o_exception,
    output logic [31:0] o_level_enable_mask,
    output logic [31:0] o_in_service,
    output logic [31:0] o_pending
);
    ////////////////////////////////////////////////////////////////////
    // synchronisers for the external pins
    logic [31:0] req_s1_q;
    logic [31:0] req_s2_q;
    logic [31:0] req_prev_q;
    logic tin_s1_q;
    logic tin_s2_q;
    logic tin_prev_q;
    logic [7:0] desc_s1_q;
    logic [7:0] desc_s2_q;
    logic [31:0] req_rise;
    logic tin_rise;

    always_ff @(posedge i_clock)
    begin
        if (!i_nrst)
        begin
            req_s1_q <= 32'h0000_0000;
            req_s2_q <= 32'h0000_0000;
            req_prev_q <= 32'h0000_0000;
            tin_s1_q <= 1'b0;
            tin_s2_q <= 1'b0;
            tin_prev_q <= 1'b0;
            desc_s1_q <= 8'h00;
            desc_s2_q <= 8'h00;
        end
        else
        begin
            req_s1_q <= i_request;
            req_s2_q <= req_s1_q;
            req_prev_q <= req_s2_q;
            tin_s1_q <= i_timing_in;
            tin_s2_q <= tin_s1_q;
            tin_prev_q <= tin_s2_q;
            desc_s1_q <= i_description;
            desc_s2_q <= desc_s1_q;
        end
    end

    assign req_rise = req_s2_q & ~req_prev_q;
    assign tin_rise = tin_s2_q & ~tin_prev_q;

    ////////////////////////////////////////////////////////////////////
    // instruction checks and exceptions
    logic do_special;
    logic op_req;
    logic spec_bad;
    pia_pkg::exc_t exc_d;
    pia_pkg::exc_t exc_q;
    logic ok_mask;
    logic ok_load;
    logic ok_special;

    assign do_special = i_status_load && i_load_special;
    assign op_req = i_status_load || i_mask_update;
    assign spec_bad = i_mask_update ? (|i_operand_low[1:0]) :
        ((|i_operand_low) || (i_load_special && (|i_instr_flags)));

    always_comb
    begin
        exc_d = pia_pkg::EXC_NONE;
        if (op_req)
        begin
            if (!i_feature_present && (do_special || i_mask_update))
                exc_d = pia_pkg::EXC_OPERATION;
            else if (i_problem_state)
                exc_d = pia_pkg::EXC_PRIVILEGED;
            else if (spec_bad)
                exc_d = pia_pkg::EXC_SPECIFICATION;
            else if (i_operand_fault)
                exc_d = pia_pkg::EXC_TERMINATED;
        end
    end

    assign ok_mask = i_mask_update && (exc_d == pia_pkg::EXC_NONE);
    assign ok_load = i_status_load && (exc_d == pia_pkg::EXC_NONE);
    assign ok_special = ok_load && i_load_special;

    always_ff @(posedge i_clock)
    begin
        if (!i_nrst)
            exc_q <= pia_pkg::EXC_NONE;
        else
            exc_q <= exc_d;
    end

    ////////////////////////////////////////////////////////////////////
    // level enable mask
    logic [31:0] word_lv;
    logic [31:0] mask_q;

    always_comb
    begin
        for (int i = 0; i < `LEVELS; i++)
            word_lv[i] = i_operand_word[31 - i];
    end

    always_ff @(posedge i_clock)
    begin
        if (!i_nrst)
            mask_q <= `MASK_RESET;
        else if (ok_mask && i_instr_flags[`MU_OR_BIT])
            mask_q <= mask_q | word_lv;
        else if (ok_mask && !i_instr_flags[`MU_CANCEL_BIT])
            mask_q <= mask_q & word_lv;
    end

    ////////////////////////////////////////////////////////////////////
    // pending and in-service latches
    level_select_if sel ();
    pia_pkg::state_t state_q;
    logic [4:0] level_q;
    logic [31:0] pend_q;
    logic [31:0] svc_q;
    logic [31:0] take_vec;
    logic [31:0] cancel_vec;
    logic [31:0] rel_vec;
    logic rel_ok;

    assign sel.clock = i_clock;
    assign sel.nrst = i_nrst;
    assign sel.pending = pend_q;
    assign sel.mask = mask_q;
    assign sel.in_service = svc_q;

    level_select u_select (
        .sel(sel.arbiter)
    );

    assign take_vec = (state_q == pia_pkg::ST_TAKE) ? (32'h0000_0001 << level_q) : 32'h0000_0000;
    assign cancel_vec = (ok_mask && i_instr_flags[`MU_CANCEL_BIT]) ? word_lv : 32'h0000_0000;
    assign rel_ok = ok_special && sel.top_valid;
    assign rel_vec = rel_ok ? (32'h0000_0001 << sel.top_level) : 32'h0000_0000;

    // a fresh request edge wins over a clear in the same cycle
    always_ff @(posedge i_clock)
    begin
        if (!i_nrst)
            pend_q <= 32'h0000_0000;
        else
            pend_q <= (pend_q & ~(cancel_vec | take_vec)) | req_rise;
    end

    always_ff @(posedge i_clock)
    begin
        if (!i_nrst)
            svc_q <= 32'h0000_0000;
        else
            svc_q <= (svc_q & ~rel_vec) | take_vec;
    end

    ////////////////////////////////////////////////////////////////////
    // taking an interruption
    logic defer_now;
    logic defer_q;
    logic go;
    logic [`DELAY_W-1:0] cnt_q;
    logic first_q;
    logic [7:0] desc_q;
    logic desc_valid_q;

    assign defer_now = i_timer_fitted && i_timer_access;
    assign go = sel.grant_valid &&
        ((i_instr_end && !defer_now) || (i_wait_state && !defer_q));

    always_ff @(posedge i_clock)
    begin
        if (!i_nrst)
            defer_q <= 1'b0;
        else if (i_instr_end)
            defer_q <= defer_now;
    end

    always_ff @(posedge i_clock)
    begin
        if (!i_nrst)
        begin
            state_q <= pia_pkg::ST_IDLE;
            level_q <= 5'h0;
            cnt_q <= '0;
            first_q <= 1'b0;
        end
        else
        begin
            first_q <= 1'b0;
            case (state_q)
                pia_pkg::ST_IDLE:
                begin
                    if (go)
                    begin
                        level_q <= sel.grant_level;
                        cnt_q <= '0;
                        if (i_basic_sync)
                        begin
                            first_q <= 1'b1;
                            state_q <= pia_pkg::ST_DELAY;
                        end
                        else
                            state_q <= pia_pkg::ST_TAKE;
                    end
                end
                pia_pkg::ST_DELAY:
                begin
                    cnt_q <= cnt_q + 1'b1;
                    if (cnt_q == `DELAY_W'(`BASIC_DELAY_CYC - 1))
                        state_q <= pia_pkg::ST_TAKE;
                end
                pia_pkg::ST_TAKE:
                    state_q <= pia_pkg::ST_STROBE;
                pia_pkg::ST_STROBE:
                begin
                    if (tin_rise)
                        state_q <= pia_pkg::ST_IDLE;
                end
                default:
                    state_q <= pia_pkg::ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge i_clock)
    begin
        if (!i_nrst)
        begin
            desc_q <= 8'h00;
            desc_valid_q <= 1'b0;
        end
        else
        begin
            desc_valid_q <= (state_q == pia_pkg::ST_STROBE) && tin_rise;
            if ((state_q == pia_pkg::ST_STROBE) && tin_rise)
                desc_q <= desc_s2_q;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // status word
    logic [63:0] status_q;

    always_ff @(posedge i_clock)
    begin
        if (!i_nrst)
            status_q <= 64'h0000_0000_0000_0000;
        else if (ok_load)
        begin
            status_q <= i_load_dword;
            status_q[`PSW_CODE] <= 16'h0000;
            status_q[`PSW_ILC] <= 2'h0;
        end
    end

    ////////////////////////////////////////////////////////////////////
    assign o_accepted_level = level_q;
    assign o_timing_out = (state_q == pia_pkg::ST_STROBE);
    assign o_description = desc_q;
    assign o_description_valid = desc_valid_q;
    assign o_basic_first = first_q;
    assign o_exchange = (state_q == pia_pkg::ST_TAKE);
    assign o_hold_async = (state_q != pia_pkg::ST_IDLE) && i_basic_async;
    assign o_deferred = defer_q;
    assign o_status_word = status_q;
    assign o_protection_key = status_q[`PSW_KEY];
    assign o_instr_address = status_q[`PSW_IA];
    assign o_cond_code = status_q[`PSW_CC];
    assign o_exception = exc_q;
    assign o_level_enable_mask = mask_q;
    assign o_in_service = svc_q;
    assign o_pending = pend_q;

    ////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (!i_nrst);

    a_take_sets_latch: assert property (state_q == pia_pkg::ST_TAKE |=> svc_q[level_q])
        else $error("take did not set latch");
    a_latch_release: assert property (|($past(svc_q) & ~svc_q) |-> $past(rel_ok))
        else $error("latch cleared without special load");
    a_release_one: assert property (rel_ok && state_q != pia_pkg::ST_TAKE |=>
        $countones(svc_q) == $countones($past(svc_q)) - 1)
        else $error("special load did not release one latch");
    a_idle_release: assert property (ok_load && !sel.top_valid &&
        state_q != pia_pkg::ST_TAKE |=> svc_q == 32'h0000_0000)
        else $error("latch appeared on plain load");
    a_mask_reset: assert property (disable iff (1'b0) !i_nrst |=> mask_q == 32'h0000_0000)
        else $error("mask not cleared by reset");
    a_mask_or: assert property (ok_mask && i_instr_flags[`MU_OR_BIT] |=>
        mask_q == ($past(mask_q) | $past(word_lv)))
        else $error("mask OR wrong");
    a_mask_and: assert property (ok_mask && i_instr_flags[7:6] == 2'h0 |=>
        mask_q == ($past(mask_q) & $past(word_lv)))
        else $error("mask AND wrong");
    a_cancel: assert property (ok_mask && i_instr_flags[`MU_CANCEL_BIT] |=>
        (pend_q & $past(word_lv) & ~$past(req_rise)) == 32'h0000_0000)
        else $error("cancel left request pending");
    a_spec_suppress: assert property (exc_d == pia_pkg::EXC_SPECIFICATION |=>
        o_exception == pia_pkg::EXC_SPECIFICATION && $stable(status_q) && $stable(mask_q))
        else $error("specification not suppressing");
    a_fields_cleared: assert property (ok_load |=>
        status_q[47:30] == 18'h0_0000 && o_cond_code == $past(i_load_dword[29:28]))
        else $error("status fields wrong after load");
    a_basic_delay: assert property (state_q == pia_pkg::ST_TAKE &&
        $past(state_q) == pia_pkg::ST_DELAY |-> $past(cnt_q) == `DELAY_W'(`BASIC_DELAY_CYC - 1))
        else $error("basic delay length wrong");
    a_strobe_order: assert property ($rose(o_timing_out) |->
        $past(state_q) == pia_pkg::ST_TAKE && $stable(o_accepted_level))
        else $error("strobe before level");
    a_desc_sample: assert property (state_q == pia_pkg::ST_STROBE && tin_rise |=>
        o_description_valid && o_description == $past(desc_s2_q) && !o_timing_out)
        else $error("description not sampled");
endmodule // priority_interrupt_arbiter

// ==== testbench/ext_equipment.sv ====
`timescale 1ns/1ps
module ext_equipment (
    input wire logic i_clock,
    input wire logic i_strobe,
    input wire logic [4:0] i_level,
    input wire logic [3:0] i_delay,
    output logic o_timing_in,
    output logic [7:0] o_byte
);
    initial
    begin
        o_timing_in = 1'b0;
        o_byte = 8'h5a;
    end
    // decode the level, present a byte, then raise timing-in
    always
    begin
        @(posedge i_clock iff i_strobe);
        repeat (i_delay) @(posedge i_clock);
        o_byte <= {3'h5, i_level};
        @(posedge i_clock);
        o_timing_in <= 1'b1;
        while (i_strobe) @(posedge i_clock);
        o_timing_in <= 1'b0;
        // released byte no longer holds the old value
        o_byte <= ~{3'h5, i_level};
    end
endmodule // ext_equipment

// ==== testbench/test_priority_interrupt_arbiter.sv ====
`timescale 1ns/1ps
module test_priority_interrupt_arbiter;
    typedef struct packed {
        logic [7:0] fl;
        logic [2:0] lo;
        logic [2:0] f;
        logic [31:0] w;
        logic [31:0] m;
        logic [2:0] e;
    } row_t;
    logic i_clock = 1'b0, i_nrst = 1'b0, i_timing_in, i_instr_end = 1'b0;
    logic i_wait_state = 1'b0, i_basic_sync = 1'b0, i_basic_async = 1'b0;
    logic i_timer_fitted = 1'b0, i_timer_access = 1'b0, i_feature_present = 1'b1;
    logic i_problem_state = 1'b0, i_mask_update = 1'b0, i_operand_fault = 1'b0;
    logic i_status_load = 1'b0, i_load_special = 1'b0, bfirst = 1'b0;
    logic [31:0] i_request = '0, i_operand_word = '0;
    logic [7:0] i_description, i_instr_flags = '0, o_description;
    logic [2:0] i_operand_low = '0;
    logic [63:0] i_load_dword = '0, o_status_word;
    logic [4:0] o_accepted_level;
    logic o_timing_out, o_description_valid, o_basic_first, o_exchange, o_hold_async, o_deferred;
    logic [3:0] o_protection_key, delay = 4'h2;
    logic [23:0] o_instr_address;
    logic [1:0] o_cond_code;
    pia_pkg::exc_t o_exception;
    logic [31:0] o_level_enable_mask, o_in_service, o_pending;
    int fail_count = 0, checked = 0, cyc, xcount = 0;
    row_t rows [9];

    priority_interrupt_arbiter dut (.i_clock, .i_nrst, .i_request, .o_accepted_level,
        .o_timing_out, .i_timing_in, .i_description, .o_description, .o_description_valid,
        .i_instr_end, .i_wait_state, .i_basic_sync, .i_basic_async, .o_basic_first,
        .o_exchange, .o_hold_async, .i_timer_fitted, .i_timer_access, .o_deferred,
        .i_feature_present, .i_problem_state, .i_mask_update, .i_instr_flags,
        .i_operand_low, .i_operand_word, .i_operand_fault, .i_status_load, .i_load_special,
        .i_load_dword, .o_status_word, .o_protection_key, .o_instr_address, .o_cond_code,
        .o_exception, .o_level_enable_mask, .o_in_service, .o_pending);
    ext_equipment equip (.i_clock(i_clock), .i_strobe(o_timing_out), .i_level(o_accepted_level),
        .i_delay(delay), .o_timing_in(i_timing_in), .o_byte(i_description));

    always #4 i_clock = ~i_clock;
    always @(posedge i_clock) if (o_basic_first === 1'b1) bfirst <= 1'b1;
    always @(posedge i_clock) if (o_exchange === 1'b1) xcount <= xcount + 1;

    ////////////////////////////////////////////////////////////////////////
    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        checked++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // one instruction pulse: mask update or status load, special unless sp is 0
    task automatic op(input logic mu, input logic [7:0] fl, input logic [2:0] lo,
        input logic [31:0] w, input logic [63:0] d, input logic [2:0] f = 3'h4,
        input logic sp = 1'b1);
        @(posedge i_clock);
        {i_feature_present, i_problem_state, i_operand_fault} <= f;
        i_mask_update <= mu;
        i_status_load <= ~mu;
        i_load_special <= sp;
        i_instr_flags <= fl;
        i_operand_low <= lo;
        i_operand_word <= w;
        i_load_dword <= d;
        @(posedge i_clock);
        i_mask_update <= 1'b0;
        i_status_load <= 1'b0;
        @(negedge i_clock);
    endtask
    task automatic pulse_end();
        @(posedge i_clock);
        i_instr_end <= 1'b1;
        @(posedge i_clock);
        i_instr_end <= 1'b0;
    endtask
    task automatic raise(input logic [31:0] r);
        @(posedge i_clock);
        i_request <= r;
        repeat (4) @(posedge i_clock);
        i_request <= '0;
    endtask
    task automatic no_take();
        pulse_end();
        repeat (8) @(negedge i_clock);
        check(o_timing_out, 1'b0);
    endtask
    task automatic take(input logic [4:0] lvl, output int c);
        int n;
        pulse_end();
        c = 0;
        while (o_timing_out !== 1'b1)
        begin
            @(negedge i_clock);
            c++;
            if (c > 700)
            begin
                fail_count++;
                end_of_test();
            end
        end
        check(o_accepted_level, lvl);
        check(o_in_service[lvl], 1'b1);
        check(o_pending[lvl], 1'b0);
        n = 0;
        while (o_description_valid !== 1'b1)
        begin
            @(negedge i_clock);
            n++;
            if (n > 40)
            begin
                fail_count++;
                end_of_test();
            end
        end
        check(o_description, {3'h5, lvl});
        check(o_timing_out, 1'b0);
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        rows = '{'{8'h80, 3'h0, 3'h4, 32'hF000_0000, 32'h0000_000F, pia_pkg::EXC_NONE},
            '{8'h00, 3'h0, 3'h4, 32'h5FFF_FFFF, 32'h0000_000A, pia_pkg::EXC_NONE},
            '{8'h80, 3'h2, 3'h4, 32'hFFFF_FFFF, 32'h0000_000A, pia_pkg::EXC_SPECIFICATION},
            '{8'h80, 3'h0, 3'h0, 32'hFFFF_FFFF, 32'h0000_000A, pia_pkg::EXC_OPERATION},
            '{8'h80, 3'h0, 3'h6, 32'hFFFF_FFFF, 32'h0000_000A, pia_pkg::EXC_PRIVILEGED},
            '{8'h80, 3'h0, 3'h5, 32'hFFFF_FFFF, 32'h0000_000A, pia_pkg::EXC_TERMINATED},
            '{8'h40, 3'h0, 3'h4, 32'hFFFF_FFFF, 32'h0000_000A, pia_pkg::EXC_NONE},
            '{8'hC0, 3'h0, 3'h4, 32'h0000_0001, 32'h8000_000A, pia_pkg::EXC_NONE},
            '{8'h00, 3'h0, 3'h4, 32'h0000_0000, 32'h0000_0000, pia_pkg::EXC_NONE}};
        repeat (12) @(posedge i_clock);
        i_nrst <= 1'b1;
        @(negedge i_clock);
        check(o_level_enable_mask, '0);
        check({o_in_service, o_pending}, '0);
        $display("test reset done");
        foreach (rows[i])
        begin
            op(1'b1, rows[i].fl, rows[i].lo, rows[i].w, '0, rows[i].f);
            check(o_exception, rows[i].e);
            check(o_level_enable_mask, rows[i].m);
        end
        $display("test mask table done");
        raise(32'h0010_0220);
        op(1'b1, 8'h80, 3'h0, 32'h0440_0000, '0);
        check(o_pending, 32'h0010_0220);
        take(5'd5, cyc);
        check(cyc < 4, 1'b1);
        no_take();
        check(o_pending, 32'h0010_0200);
        raise(32'h0000_0004);
        op(1'b1, 8'h80, 3'h0, 32'h2000_0000, '0);
        take(5'd2, cyc);
        check(o_in_service, 32'h0000_0024);
        op(1'b0, 8'h01, 3'h0, '0, '0);
        check(o_exception, pia_pkg::EXC_SPECIFICATION);
        op(1'b0, 8'h00, 3'h4, '0, '0);
        check({o_exception, o_in_service}, {pia_pkg::EXC_SPECIFICATION, 32'h0000_0024});
        op(1'b0, 8'h01, 3'h0, '0, 64'h0000_0000_0000_0123, 3'h4, 1'b0);
        check({o_exception, o_in_service, o_instr_address}, {3'h0, 32'h0000_0024, 24'h00_0123});
        op(1'b0, 8'h00, 3'h0, '0, 64'h00A3_FFFF_F012_3456);
        check(o_in_service, 32'h0000_0020);
        check({o_protection_key, o_instr_address}, 28'hA12_3456);
        check(o_status_word[47:30], '0);
        check(o_cond_code, 2'h3);
        check(o_level_enable_mask, 32'h0000_0224);
        no_take();
        op(1'b0, 8'h00, 3'h0, '0, '0);
        check(o_in_service, '0);
        take(5'd9, cyc);
        op(1'b0, 8'h00, 3'h0, '0, '0);
        op(1'b0, 8'h00, 3'h0, '0, 64'h0000_0000_0000_0ABC);
        check({o_exception, o_in_service, o_instr_address}, {3'h0, 32'h0, 24'h00_0ABC});
        op(1'b1, 8'h40, 3'h0, 32'h0000_0800, '0);
        check(o_pending, '0);
        $display("test priority done");
        @(posedge i_clock);
        i_timer_fitted <= 1'b1;
        i_timer_access <= 1'b1;
        raise(32'h0000_0080);
        op(1'b1, 8'h80, 3'h0, 32'h0100_0000, '0);
        no_take();
        check(o_deferred, 1'b1);
        @(posedge i_clock);
        i_wait_state <= 1'b1;
        repeat (6) @(negedge i_clock);
        check(o_timing_out, 1'b0);
        @(posedge i_clock);
        i_timer_access <= 1'b0;
        take(5'd7, cyc);
        check(o_deferred, 1'b0);
        op(1'b0, 8'h00, 3'h0, '0, '0);
        raise(32'h0000_0040);
        i_basic_async <= 1'b1;
        op(1'b1, 8'h80, 3'h0, 32'h0200_0000, '0);
        repeat (2) @(negedge i_clock);
        check(o_timing_out, 1'b1);
        check({o_hold_async, bfirst}, 2'b10);
        take(5'd6, cyc);
        check(o_hold_async, 1'b0);
        i_wait_state <= 1'b0;
        i_basic_async <= 1'b0;
        op(1'b0, 8'h00, 3'h0, '0, '0);
        $display("test timer done");
        @(posedge i_clock);
        delay <= 4'h6;
        i_basic_sync <= 1'b1;
        raise(32'h0000_0008);
        op(1'b1, 8'h80, 3'h0, 32'h1000_0000, '0);
        take(5'd3, cyc);
        check({bfirst, cyc > 500}, 2'h3);
        i_basic_sync <= 1'b0;
        op(1'b0, 8'h00, 3'h0, '0, '0);
        check(o_in_service, '0);
        check(xcount, 6);
        check(o_level_enable_mask, 32'h0000_02EC);
        $display("test basic clash done");
        raise(32'h0000_0002);
        check(o_pending, 32'h0000_0002);
        @(posedge i_clock);
        i_nrst <= 1'b0;
        repeat (3) @(posedge i_clock);
        i_nrst <= 1'b1;
        @(negedge i_clock);
        check(o_level_enable_mask, '0);
        check({o_pending, o_in_service, o_exception}, '0);
        $display("test mid reset done");
        end_of_test();
    end
endmodule // test_priority_interrupt_arbiter
